/* File: cs_tick_gen.sv */
// holds the shared constant package and the crystal tick generator
// assumes one 200 MHz system clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

package cs_pkg;
   // clock rates
   localparam int SYS_HZ        = 200_000_000;
   localparam int XTAL_HZ       = 32_768;
   localparam int MS_PER_S      = 1000;
   // times in ms as printed
   localparam int WDOG_LONG_MS  = 1750;
   localparam int WDOG_MID_MS   = 750;
   localparam int WDOG_SHORT_MS = 250;
   localparam int WDOG_RST_MS   = 250;
   localparam int POR_MS        = 250;
   localparam int NVWC_TYP_MS   = 5;
   localparam int NVWC_MAX_MS   = 10;
   // counts in crystal ticks and system cycles
   localparam int WDOG_LONG_TK  = WDOG_LONG_MS * XTAL_HZ / MS_PER_S;
   localparam int WDOG_MID_TK   = WDOG_MID_MS * XTAL_HZ / MS_PER_S;
   localparam int WDOG_SHORT_TK = WDOG_SHORT_MS * XTAL_HZ / MS_PER_S;
   localparam int WDOG_RST_TK   = WDOG_RST_MS * XTAL_HZ / MS_PER_S;
   localparam int POR_TK        = POR_MS * XTAL_HZ / MS_PER_S;
   localparam int NVWC_CYC      = NVWC_TYP_MS * (SYS_HZ / MS_PER_S);
   // widths
   localparam int TK_W          = 17;
   localparam int NV_W          = 21;
   localparam int ACC_W         = 28;
   // period select encodings {hi, lo}
   localparam logic [1:0] SEL_LONG  = 2'h0;
   localparam logic [1:0] SEL_MID   = 2'h1;
   localparam logic [1:0] SEL_SHORT = 2'h2;
   localparam logic [1:0] SEL_OFF   = 2'h3;
   typedef enum logic [1:0] {ST_POR, ST_RUN, ST_WDRST} cs_state_t;
endpackage

module cs_tick_gen
   import cs_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // one-cycle strobe at the crystal rate
   output var  logic tick_o
);
   logic [ACC_W-1:0] acc_r;
   logic [ACC_W-1:0] acc_nxt;
   logic             tick_nxt;

   // fractional divider: no drift, jitter of one system cycle is harmless here
   always_comb begin
      acc_nxt  = acc_r + ACC_W'(XTAL_HZ);
      tick_nxt = 1'b0;
      if (acc_nxt >= ACC_W'(SYS_HZ)) begin
         acc_nxt  = acc_nxt - ACC_W'(SYS_HZ);
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         acc_r  <= '0;
         tick_o <= 1'b0;
      end else begin
         acc_r  <= acc_nxt;
         tick_o <= tick_nxt;
      end
   end
endmodule // cs_tick_gen

`default_nettype wire

/* File: cs_supervisor.sv */
// supervisor: power-on delay, low-supply reset, watchdog, nonvolatile write timer
// assumes select, service and write-stop come from logic on sys_clk;
// the low-supply comparator is asynchronous and is synchronised here
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - select 00=1.75s, 01=750ms, 10=250ms from crystal
// - three periods plus an off setting
// - unserviced period expiry asserts reset output
// - hold reset 250 ms after watchdog expiry
// - hold reset 250 ms after power-up
// - low supply forces reset output active
// - stop after write starts self-timed write cycle
// - reset output active low, open drain
module cs_supervisor
   import cs_pkg::*;
#(
   parameter int P_LONG_TK  = WDOG_LONG_TK,
   parameter int P_MID_TK   = WDOG_MID_TK,
   parameter int P_SHORT_TK = WDOG_SHORT_TK,
   parameter int P_RST_TK   = WDOG_RST_TK,
   parameter int P_POR_TK   = POR_TK,
   parameter int P_NVWC_CYC = NVWC_CYC
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // watchdog control from software-owned bits
   input  wire logic wdog_period_sel_hi,
   input  wire logic wdog_period_sel_lo,
   input  wire logic wdog_service,
   // supply comparator, high when supply is under the trip level
   input  wire logic low_supply_sense,
   // valid stop ending a write sequence
   input  wire logic nv_write_stop,
   // open-drain reset pin
   output var  logic rst_pin_n_o,
   output var  logic rst_pin_oe,
   // nonvolatile write cycle in progress
   output var  logic nv_busy_o
);
   logic            tick;
   logic            lvs_meta_r;
   logic            lvs_s_r;
   logic [1:0]      sel;
   logic [1:0]      sel_prev_r;
   logic            sel_chg;
   logic [TK_W-1:0] per_lim;
   cs_state_t       st_r;
   cs_state_t       st_nxt;
   logic [TK_W-1:0] tk_r;
   logic [TK_W-1:0] tk_nxt;
   logic [TK_W-1:0] watchdog_counter;
   logic [TK_W-1:0] wd_nxt;
   logic            oe_nxt;
   logic [NV_W-1:0] nv_cnt_r;
   logic [NV_W-1:0] nv_cnt_nxt;
   logic            nv_busy_nxt;

   cs_tick_gen u_tick (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .tick_o  (tick)
   );

   // comparator output is asynchronous, two flops before use
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lvs_meta_r <= 1'b0;
         lvs_s_r    <= 1'b0;
         sel_prev_r <= SEL_LONG;
      end else begin
         lvs_meta_r <= low_supply_sense;
         lvs_s_r    <= lvs_meta_r;
         sel_prev_r <= sel;
      end
   end

   // period decode
   assign sel     = {wdog_period_sel_hi, wdog_period_sel_lo};
   assign sel_chg = (sel != sel_prev_r);
   always_comb begin
      case (sel)
         SEL_MID:   per_lim = TK_W'(P_MID_TK - 1);
         SEL_SHORT: per_lim = TK_W'(P_SHORT_TK - 1);
         default:   per_lim = TK_W'(P_LONG_TK - 1);
      endcase
   end

   // reset sequencer and watchdog counter
   always_comb begin
      st_nxt = st_r;
      tk_nxt = tk_r;
      wd_nxt = watchdog_counter;
      case (st_r)
         ST_POR: begin
            if (lvs_s_r) begin
               tk_nxt = '0; // delay starts again once supply is good
            end else if (tick) begin
               if (tk_r >= TK_W'(P_POR_TK - 1)) begin
                  st_nxt = ST_RUN;
                  tk_nxt = '0;
                  wd_nxt = '0;
               end else begin
                  tk_nxt = tk_r + TK_W'(1);
               end
            end
         end
         ST_RUN: begin
            if (lvs_s_r) begin
               st_nxt = ST_POR;
               tk_nxt = '0;
               wd_nxt = '0; // stale count must not survive into the next run
            end else if (sel == SEL_OFF || sel_chg || wdog_service) begin
               wd_nxt = '0;
            end else if (tick) begin
               if (watchdog_counter >= per_lim) begin
                  st_nxt = ST_WDRST;
                  tk_nxt = '0;
                  wd_nxt = '0;
               end else begin
                  wd_nxt = watchdog_counter + TK_W'(1);
               end
            end
         end
         ST_WDRST: begin
            if (lvs_s_r) begin
               st_nxt = ST_POR;
               tk_nxt = '0;
            end else if (tick) begin
               if (tk_r >= TK_W'(P_RST_TK - 1)) begin
                  st_nxt = ST_RUN;
                  tk_nxt = '0;
                  wd_nxt = '0;
               end else begin
                  tk_nxt = tk_r + TK_W'(1);
               end
            end
         end
         default: begin
            st_nxt = ST_POR;
            tk_nxt = '0;
            wd_nxt = '0;
         end
      endcase
      oe_nxt = (st_nxt != ST_RUN);
   end

   // pin level is always low; only the enable moves, so the wire is never driven high
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r             <= ST_POR;
         tk_r             <= '0;
         watchdog_counter <= '0;
         rst_pin_n_o      <= 1'b0;
         rst_pin_oe       <= 1'b1;
      end else begin
         st_r             <= st_nxt;
         tk_r             <= tk_nxt;
         watchdog_counter <= wd_nxt;
         rst_pin_n_o      <= 1'b0;
         rst_pin_oe       <= oe_nxt;
      end
   end

   // self-timed write cycle; a stop while busy is ignored (host should poll)
   always_comb begin
      nv_busy_nxt = nv_busy_o;
      nv_cnt_nxt  = nv_cnt_r;
      if (nv_busy_o) begin
         if (nv_cnt_r >= NV_W'(P_NVWC_CYC - 1)) begin
            nv_busy_nxt = 1'b0;
            nv_cnt_nxt  = '0;
         end else begin
            nv_cnt_nxt = nv_cnt_r + NV_W'(1);
         end
      end else if (nv_write_stop) begin
         nv_busy_nxt = 1'b1;
         nv_cnt_nxt  = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         nv_busy_o <= 1'b0;
         nv_cnt_r  <= '0;
      end else begin
         nv_busy_o <= nv_busy_nxt;
         nv_cnt_r  <= nv_cnt_nxt;
      end
   end

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   short_expiry_a: assert property (
      st_r == ST_RUN && !lvs_s_r && sel == SEL_SHORT && !sel_chg && !wdog_service && tick
      && watchdog_counter == TK_W'(P_SHORT_TK - 1) |=> st_r == ST_WDRST ##0 rst_pin_oe)
      else $error("short period expiry did not assert reset");
   wdog_off_a: assert property (
      st_r == ST_RUN && sel == SEL_OFF |=> watchdog_counter == '0 && st_r != ST_WDRST)
      else $error("watchdog counted while off");
   expiry_reset_a: assert property (
      st_r == ST_WDRST |-> rst_pin_oe && !rst_pin_n_o)
      else $error("reset pin released during watchdog reset");
   wd_hold_a: assert property (
      st_r == ST_WDRST && !lvs_s_r && tick && tk_r < TK_W'(P_RST_TK - 1)
      |=> st_r == ST_WDRST)
      else $error("watchdog reset ended early");
   wd_release_a: assert property (
      st_r == ST_WDRST && !lvs_s_r && tick && tk_r == TK_W'(P_RST_TK - 1)
      |=> st_r == ST_RUN ##0 !rst_pin_oe)
      else $error("watchdog reset not released on time");
   por_release_a: assert property (
      st_r == ST_POR && !lvs_s_r && tick && tk_r == TK_W'(P_POR_TK - 1)
      |=> !rst_pin_oe ##1 (rst_pin_oe == $past(lvs_s_r)))
      else $error("power-on delay not released on time");
   low_supply_a: assert property (
      lvs_s_r |=> rst_pin_oe)
      else $error("low supply did not assert reset");
   nv_start_a: assert property (
      nv_write_stop && !nv_busy_o |=> nv_busy_o && nv_cnt_r == '0)
      else $error("write cycle did not start");
   nv_end_a: assert property (
      nv_busy_o && nv_cnt_r == NV_W'(P_NVWC_CYC - 1) |=> !nv_busy_o)
      else $error("write cycle did not end on time");
   // the enable follows the synchronised sense one cycle late
   pin_release_a: assert property (
      !rst_pin_oe |-> st_r == ST_RUN && !$past(lvs_s_r))
      else $error("pin released outside normal run");
   sel_restart_a: assert property (
      st_r == ST_RUN && !lvs_s_r && sel_chg |=> watchdog_counter == '0)
      else $error("counter kept running across select change");

   wd_cycle_c: cover property (st_r == ST_WDRST ##1 st_r == ST_RUN);
   lvs_c: cover property (st_r == ST_RUN ##1 lvs_s_r ##1 st_r == ST_POR);
   nv_c: cover property (nv_busy_o ##1 !nv_busy_o);
   service_c: cover property (st_r == ST_RUN && wdog_service && watchdog_counter != '0);
endmodule // cs_supervisor

`default_nettype wire

/* File: cs_host_model.sv */
// host processor model facing the supervisor: kicks, write stops, reset pull-up
// assumes the bench owns clock and reset and raises the kick and write requests
`timescale 1ns/1ps
`default_nettype none
module cs_host_model #(
   parameter int P_RD_WAIT = 8,
   parameter int P_WR_WAIT = 40
) (
   // clock
   input  wire logic sys_clk,
   // requests from the bench
   input  wire logic kick_req,
   input  wire logic wr_req,
   // device side
   input  wire logic rst_pin_n_o,
   input  wire logic rst_pin_oe,
   input  wire logic nv_busy_o,
   output var  logic wdog_service = 1'b0,
   output var  logic nv_write_stop = 1'b0,
   output wire logic rst_pin
);
   int up_cnt = 0;
   // a released pin reads high through the external pull-up
   assign rst_pin = rst_pin_oe ? rst_pin_n_o : 1'b1;
   // host is held while the pin is low; it writes only after a settle wait and a finished cycle
   always @(posedge sys_clk) begin
      up_cnt <= (rst_pin === 1'b1) ? up_cnt + 1 : 0;
      wdog_service <= kick_req & (rst_pin === 1'b1) & (up_cnt > P_RD_WAIT);
      nv_write_stop <= wr_req & (up_cnt > P_WR_WAIT) & !nv_busy_o & !nv_write_stop;
   end
endmodule // cs_host_model
`default_nettype wire

/* File: cs_supervisor_tb_top.sv */
// self-checking bench: power-on delay, watchdog, low supply, write timer
// assumes cs_tick_gen.sv, cs_supervisor.sv and cs_host_model.sv compile first
`timescale 1ns/1ps
`default_nettype none
module cs_supervisor_tb_top;
   import cs_pkg::*;
   localparam int T      = 6104; // system cycles per crystal tick, rounded up
   localparam int RST_TK = 2;
   localparam int POR_S  = 2;
   localparam int SHT_TK = 2;
   localparam int NV_CYC = 20;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sel_hi = 1'b0, sel_lo = 1'b0, low_sense = 1'b0, kick = 1'b0, wr = 1'b0;
   wire logic svc, stop, pin_n, pin_oe, busy, pin;
   int bad_count = 0, num_checks = 0, busy_len = 0, low_len = 0, sel_base = 0;
   int busy_q[$], low_q[$];

   always #2.5 sys_clk = ~sys_clk;

   cs_supervisor #(.P_LONG_TK(4), .P_MID_TK(3), .P_SHORT_TK(SHT_TK), .P_RST_TK(RST_TK),
      .P_POR_TK(POR_S), .P_NVWC_CYC(NV_CYC)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .wdog_period_sel_hi(sel_hi), .wdog_period_sel_lo(sel_lo), .wdog_service(svc),
      .low_supply_sense(low_sense), .nv_write_stop(stop), .rst_pin_n_o(pin_n),
      .rst_pin_oe(pin_oe), .nv_busy_o(busy));
   cs_host_model u_host (.sys_clk(sys_clk), .kick_req(kick), .wr_req(wr),
      .rst_pin_n_o(pin_n), .rst_pin_oe(pin_oe), .nv_busy_o(busy),
      .wdog_service(svc), .nv_write_stop(stop), .rst_pin(pin));

   task automatic step(int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk_cnt(string what, int e, int g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %0d seen %0d", what, e, g);
      end
   endtask
   task automatic chk_pin(string what, logic e);
      #1;
      num_checks++;
      if (pin !== e) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", what, e, pin);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // monitor: lengths of busy and of reset-pin low, compared when each ends; a pin low only when a length is queued
   always @(posedge sys_clk) begin
      busy_len <= (busy === 1'b1) ? busy_len + 1 : 0;
      low_len <= (pin === 1'b0) ? low_len + 1 : 0;
      if (busy === 1'b0 && busy_len > 0) begin
         chk_cnt("write busy cycles", busy_q.pop_front(), busy_len);
      end
      if (pin === 1'b1 && low_len > 0 && low_q.size() > 0) begin
         chk_cnt("reset ticks", low_q.pop_front(), (low_len + T / 2) / T);
      end
   end

   // watchdog on the run: a hang counts as a mismatch
   initial begin
      step(16 * T);
      bad_count++;
      print_verdict();
   end

   initial begin
      void'($urandom(32'h6173));
      sel_base = $urandom_range(2);
      step(4);
      sys_rst <= 1'b0;
      step(T - 200);
      chk_pin("pin in power-on delay", 1'b0);
      step(T + 400);
      chk_pin("pin after power-on delay", 1'b1);
      // kicks at random spacing inside every period, select moving too
      for (int i = 0; i < 6; i++) begin
         step(1);
         {sel_hi, sel_lo} <= 2'((sel_base + i) % 3); // rotate so every period is visited
         kick <= 1'b1;
         step(1);
         kick <= 1'b0;
         step($urandom_range(3000, 500));
         chk_pin("pin while serviced", 1'b1);
      end
      // last kick on the shortest period, then silence until expiry
      step(1);
      {sel_hi, sel_lo} <= SEL_SHORT;
      kick <= 1'b1;
      low_q.push_back(RST_TK);
      step(1);
      kick <= 1'b0;
      step((SHT_TK - 1) * T - 50);
      chk_pin("pin before expiry", 1'b1);
      step(T + 60);
      chk_pin("pin after expiry", 1'b0);
      step(RST_TK * T + 100);
      chk_pin("pin after reset hold", 1'b1);
      // off setting: no kicks and still no expiry
      step(1);
      {sel_hi, sel_lo} <= SEL_OFF;
      step(SHT_TK * T + 200);
      chk_pin("pin with watchdog off", 1'b1);
      // two write stops back to back, each timed in full
      for (int i = 0; i < 2; i++) begin
         step(1);
         wr <= 1'b1;
         busy_q.push_back(NV_CYC);
         step(1);
         wr <= 1'b0;
         step(NV_CYC + 4);
      end
      // low supply pulls the pin at once, recovery restarts the power-on delay
      step(1);
      low_sense <= 1'b1;
      step(4);
      chk_pin("pin on low supply", 1'b0);
      step(20);
      low_sense <= 1'b0;
      step(T - 200);
      chk_pin("pin in restarted delay", 1'b0);
      step(T + 400);
      chk_pin("pin after recovery", 1'b1);
      print_verdict();
   end
endmodule // cs_supervisor_tb_top
`default_nettype wire
